// *** pec_counter.sv ***
// Free running event counter with prescaler and edge synchroniser
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_counter #(
  parameter int CNT_WIDTH   = `PEC_CNT_WIDTH,
  parameter int DELAY_CLKS  = `PEC_DELAY_CLKS,
  parameter int INHIBIT_CYC = `PEC_INHIBIT_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Counter as file register
  input  wire logic                  cntWrite,
  input  wire logic [CNT_WIDTH-1:0]  cntWdata,
  output logic      [CNT_WIDTH-1:0]  cntRdata,
  // Configuration load
  input  wire logic                  cfgWrite,
  input  wire pec_pkg::pec_byte_t    cfgWdata,
  output pec_pkg::pec_byte_t         cfgRdata,
  // External count pin
  input  wire logic                  countPin,
  // Instruction rate clock
  output logic                       instrClockOut
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [3:0] INHIBIT_CLKS =
    4'(INHIBIT_CYC * `PEC_QPHASES);
  localparam int LAT_LO = `PEC_LAT_MIN_CLKS;
  localparam int LAT_HI = `PEC_LAT_MAX_CLKS;

  pec_div_if dvIf ();

  pec_pkg::pec_byte_t     cfg;
  pec_pkg::pec_src_e      srcSel;
  pec_pkg::pec_edge_e     edgeSel;
  logic                   assigned;
  logic [1:0]             qPhase;
  logic [1:0]             next_qPhase;
  logic                   instrLevel;
  logic                   srcLevel;
  logic                   sampleTick;
  logic                   lastSample;
  logic                   syncPulse;
  logic [DELAY_CLKS-1:0]  delayLine;
  logic                   incPulse;
  logic [3:0]             inhibit;
  logic                   incApplied;
  logic [CNT_WIDTH-1:0]   count;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `PEC_CFG_RESET;
    end else if (cfgWrite) begin
      cfg <= cfgWdata;
    end
  end

  assign cfgRdata = cfg;
  assign srcSel   = pec_pkg::pec_src_e'(cfg[`PEC_CFG_SRC_BIT]);
  assign edgeSel  = pec_pkg::pec_edge_e'(cfg[`PEC_CFG_EDGE_BIT]);
  // Assign bit low places the divider in front of the counter
  assign assigned = ~cfg[`PEC_CFG_ASSIGN_BIT];

  // ****************************************************************
  // Instruction clock phases
  // ****************************************************************
  assign next_qPhase = qPhase + 2'h1;
  assign instrLevel  = qPhase[1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qPhase <= 2'h0;
    end else begin
      qPhase <= next_qPhase;
    end
  end

  // Registered so the pin output is glitch free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instrClockOut <= 1'b0;
    end else begin
      instrClockOut <= next_qPhase[1];
    end
  end

  // ****************************************************************
  // Count source selection
  // ****************************************************************
  // Falling-edge mode inverts the pin so everything downstream
  // only ever looks for rising edges
  always_comb begin
    if (srcSel == pec_pkg::PEC_SRC_EXT) begin
      srcLevel = countPin ^ (edgeSel == pec_pkg::PEC_EDGE_FALL);
    end else begin
      srcLevel = instrLevel;
    end
  end

  // ****************************************************************
  // Divider
  // ****************************************************************
  assign dvIf.srcLevel = srcLevel;
  assign dvIf.clear    = cntWrite & assigned;
  assign dvIf.assigned = assigned;
  assign dvIf.ratio    = cfg[`PEC_CFG_PS_MSB:`PEC_CFG_PS_LSB];

  pec_divider #(
    .DIV_WIDTH (`PEC_DIV_WIDTH)
  ) u_divider (
    .clk   (clk),
    .rst_b (rst_b),
    .dv    (dvIf.div)
  );

  // ****************************************************************
  // Synchroniser: two samples per instruction cycle
  // ****************************************************************
  // Pulses shorter than two oscillator periods can fall between
  // samples and be lost; the source must respect that
  assign sampleTick = (qPhase == `PEC_SAMPLE_PH_A) ||
                      (qPhase == `PEC_SAMPLE_PH_B);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Starts high: a source resting high after reset is no edge
      lastSample <= 1'b1;
      syncPulse  <= 1'b0;
    end else if (sampleTick) begin
      lastSample <= dvIf.divOut;
      syncPulse  <= dvIf.divOut & ~lastSample;
    end else begin
      syncPulse  <= 1'b0;
    end
  end

  // ****************************************************************
  // Increment delay and write hold-off
  // ****************************************************************
  // A write flushes pulses in flight: they belong to the old value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delayLine <= '0;
    end else if (cntWrite) begin
      delayLine <= '0;
    end else begin
      delayLine <= {delayLine[DELAY_CLKS-2:0], syncPulse};
    end
  end

  assign incPulse = delayLine[DELAY_CLKS-1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inhibit <= 4'h0;
    end else if (cntWrite) begin
      inhibit <= INHIBIT_CLKS;
    end else if (inhibit != 4'h0) begin
      inhibit <= inhibit - 4'h1;
    end
  end

  assign incApplied = incPulse && (inhibit == 4'h0) && !cntWrite;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= `PEC_CNT_RESET;
    end else if (cntWrite) begin
      count <= cntWdata;
    end else if (incApplied) begin
      count <= count + 1'b1;
    end
  end

  assign cntRdata = count;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_write_quiet;
    cntWrite ##1 (!cntWrite)[*8];
  endsequence

  sequence s_pulse_clear;
    (syncPulse && !cntWrite) ##1 !cntWrite;
  endsequence

  sequence s_ext_rise;
    $rose(countPin) && srcSel == pec_pkg::PEC_SRC_EXT &&
      edgeSel == pec_pkg::PEC_EDGE_RISE && !assigned &&
      inhibit == 4'h0 && !cntWrite && !cfgWrite;
  endsequence

  sequence s_instr_cycle;
    instrClockOut ##1 !instrClockOut ##1 !instrClockOut ##1 instrClockOut;
  endsequence

  a_write_loads: assert property (
    cntWrite |=> cntRdata == $past(cntWdata))
    else $error("counter write not loaded");

  a_write_holdoff: assert property (
    s_write_quiet |-> cntRdata == $past(cntWdata, 8))
    else $error("counter moved inside write hold-off");

  a_wrap_zero: assert property (
    (count == `PEC_CNT_MAX && incApplied) |=> count == `PEC_CNT_RESET)
    else $error("counter did not wrap to zero");

  a_inc_delay: assert property (
    s_pulse_clear |-> ##1 incPulse)
    else $error("increment pulse not delayed as expected");

  a_sample_tick: assert property (
    syncPulse |-> $past(sampleTick) && $past(dvIf.divOut))
    else $error("edge seen outside a sample point");

  a_ext_source: assert property (
    srcSel == pec_pkg::PEC_SRC_EXT |->
      srcLevel == (countPin ^ edgeSel))
    else $error("external source level wrong");

  a_int_source: assert property (
    srcSel == pec_pkg::PEC_SRC_INT |-> srcLevel == qPhase[1])
    else $error("internal source depends on pin or edge bit");

  a_ext_latency: assert property (
    s_ext_rise |-> ##[LAT_LO:LAT_HI] incPulse)
    else $error("external edge latency out of range");

  a_prescale_clr: assert property (
    (cntWrite && assigned && !cfgWrite) |=> !dvIf.divOut)
    else $error("counter write did not clear divider");

  a_instr_clock: assert property (
    $rose(instrClockOut) |=> s_instr_cycle)
    else $error("instruction clock not osc divided by four");

  a_cfg_loads: assert property (
    cfgWrite |=> cfgRdata == $past(cfgWdata))
    else $error("configuration write not loaded");

  a_count_idle: assert property (
    (!cntWrite && !incPulse) |=> cntRdata == $past(cntRdata))
    else $error("counter moved without increment or write");

  a_inc_step: assert property (
    incApplied |=> cntRdata == $past(cntRdata) + 1'b1)
    else $error("applied increment did not add one");

  a_write_flush: assert property (
    cntWrite |=> delayLine == '0)
    else $error("pulses in flight survived a counter write");

  a_inhibit_load: assert property (
    cntWrite |=> inhibit == INHIBIT_CLKS)
    else $error("hold-off not restarted by counter write");

  a_inc_source: assert property (
    incPulse |-> $past(syncPulse, 2))
    else $error("increment pulse without a synchronised edge");

  a_sync_rise: assert property (
    syncPulse |-> !$past(lastSample))
    else $error("edge pulse without a low sample before it");

  a_sample_load: assert property (
    sampleTick |=> lastSample == $past(dvIf.divOut))
    else $error("sample point did not capture divider output");

  a_sync_single: assert property (
    syncPulse |=> !syncPulse)
    else $error("edge pulse longer than one clock");

endmodule

// *** pec_consts.svh ***
// Offsets, field positions, reset values and timing counts of the counter
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// ****************************************************************
// Configuration field layout
// ****************************************************************
`define PEC_CFG_WIDTH        8
`define PEC_CFG_PS_LSB       0
`define PEC_CFG_PS_MSB       2
`define PEC_CFG_ASSIGN_BIT   3
`define PEC_CFG_EDGE_BIT     4
`define PEC_CFG_SRC_BIT      5
`define PEC_CFG_RESET        8'hff

// ****************************************************************
// Counter and divider
// ****************************************************************
`define PEC_CNT_WIDTH        8
`define PEC_CNT_RESET        8'h00
`define PEC_CNT_MAX          8'hff
`define PEC_DIV_WIDTH        8

// ****************************************************************
// Timing
// ****************************************************************
`define PEC_CLK_PERIOD_NS    100
`define PEC_TOSC_NS          100
`define PEC_QPHASES          4
`define PEC_SAMPLE_PH_A      2'h1
`define PEC_SAMPLE_PH_B      2'h3
`define PEC_INHIBIT_CYC      2
`define PEC_DELAY_CLKS       2
`define PEC_LAT_MIN_TOSC     3
`define PEC_LAT_MAX_TOSC     7
`define PEC_LAT_MIN_CLKS \
  ((`PEC_LAT_MIN_TOSC * `PEC_TOSC_NS + `PEC_CLK_PERIOD_NS - 1) \
   / `PEC_CLK_PERIOD_NS)
`define PEC_LAT_MAX_CLKS \
  ((`PEC_LAT_MAX_TOSC * `PEC_TOSC_NS) / `PEC_CLK_PERIOD_NS)

`endif

// *** pec_pkg.sv ***
// Types shared by the counter and its divider
package pec_pkg;

  typedef enum logic {
    PEC_SRC_INT = 1'b0,
    PEC_SRC_EXT = 1'b1
  } pec_src_e;

  typedef enum logic {
    PEC_EDGE_RISE = 1'b0,
    PEC_EDGE_FALL = 1'b1
  } pec_edge_e;

  typedef logic [7:0] pec_byte_t;
  typedef logic [2:0] pec_ratio_t;

endpackage

// *** pec_div_if.sv ***
// Carrier between the counter core and its divider
`timescale 1ns/1ns
interface pec_div_if;
  logic                srcLevel;
  logic                clear;
  logic                assigned;
  pec_pkg::pec_ratio_t ratio;
  logic                divOut;

  modport core (output srcLevel, output clear, output assigned,
                output ratio, input divOut);
  modport div  (input srcLevel, input clear, input assigned,
                input ratio, output divOut);
endinterface

// *** pec_divider.sv ***
// Ripple-style prescale divider placed in front of the counter
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_divider #(
  parameter int DIV_WIDTH = `PEC_DIV_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core side
  pec_div_if.div   dv
);

  logic [DIV_WIDTH-1:0] divCount;
  logic                 prevSrc;
  logic                 srcRise;

  assign srcRise = dv.srcLevel & ~prevSrc;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // High so a source resting high after reset is not a rise
      prevSrc <= 1'b1;
    end else begin
      prevSrc <= dv.srcLevel;
    end
  end

  // Each bit toggles at half the rate of the one below: square output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= '0;
    end else if (dv.clear) begin
      divCount <= '0;
    end else if (srcRise) begin
      divCount <= divCount + 1'b1;
    end
  end

  // Ratio field n gives divide by 2^(n+1); unassigned passes through
  always_comb begin
    if (dv.assigned) begin
      dv.divOut = divCount[dv.ratio];
    end else begin
      dv.divOut = dv.srcLevel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_div_clear: assert property (dv.clear |=> divCount == '0)
    else $error("divider not cleared by counter write");
  a_div_step: assert property (
    (srcRise && !dv.clear) |=> divCount == $past(divCount) + 1'b1)
    else $error("divider did not step on source rise");
  a_div_bypass: assert property (
    !dv.assigned |-> dv.divOut == dv.srcLevel)
    else $error("unassigned divider does not pass source");

endmodule

// *** pec_pin_src.sv ***
// Model of the external source that drives the count pin
`timescale 1ns/1ns
module pec_pin_src (
  // Clock
  input  wire logic       clk,
  // Control from the bench
  input  wire logic       run,
  input  wire logic [3:0] halfClks,
  // Count pin
  output logic            countPin
);
  logic [3:0] held;

  initial countPin = 1'b0;
  initial held = 4'h0;

  // Level stands still while idle; each level lasts halfClks, or one clock
  // when halfClks is below two, too short for the twice-per-cycle sampler
  always @(posedge clk) begin
    if (run && held + 4'h1 >= halfClks) begin
      countPin <= #10 ~countPin;
      held <= 4'h0;
    end else if (run) begin
      held <= held + 4'h1;
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the prescaled event counter
`timescale 1ns/1ns
module tb_top;
  // ********
  // Signals
  // ********
  logic               clk      = 1'b0;
  logic               rst_b    = 1'b0;
  logic               cntWrite = 1'b0;
  logic [7:0]         cntWdata = 8'h00;
  logic [7:0]         cntRdata;
  logic               cfgWrite = 1'b0;
  pec_pkg::pec_byte_t cfgWdata = 8'h00;
  pec_pkg::pec_byte_t cfgRdata;
  logic               countPin;
  logic               instrClockOut;
  logic               run      = 1'b0;
  logic [3:0]         halfClks = 4'h3;
  logic [7:0]         v;
  logic [7:0]         c;
  logic [7:0]         ph;
  int                 fails    = 0;
  int                 n_tests  = 0;
  int                 rises    = 0;
  int                 falls    = 0;
  int                 n;
  time                pinT     = 0;

  always #50 clk = ~clk;

  pec_counter u_pec_counter (
    .clk(clk), .rst_b(rst_b),
    .cntWrite(cntWrite), .cntWdata(cntWdata), .cntRdata(cntRdata),
    .cfgWrite(cfgWrite), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
    .countPin(countPin), .instrClockOut(instrClockOut)
  );
  pec_pin_src u_pec_pin_src (
    .clk(clk), .run(run), .halfClks(halfClks), .countPin(countPin)
  );

  always @(countPin) begin
    pinT = $time;
    if (countPin === 1'b1) rises++;
    else falls++;
  end

  // ********
  // Tasks
  // ********
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input logic [7:0] got, lo, hi);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wcnt(input logic [7:0] d);
    cntWrite = 1'b1;
    cntWdata = d;
    tick(1);
    cntWrite = 1'b0;
  endtask

  task automatic wcfg(input logic [7:0] d);
    cfgWrite = 1'b1;
    cfgWdata = d;
    tick(1);
    cfgWrite = 1'b0;
  endtask

  // Bounded wait for the counter to move; a hang ends the run
  task automatic wait_chg;
    logic [7:0] o;
    o = cntRdata;
    n = 0;
    while (cntRdata === o && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      tally_and_finish;
    end
  endtask

  // Divider shift: 0 when bypassed, else ratio field plus one
  function automatic int sh(input logic [7:0] cf);
    return cf[3] ? 0 : int'(cf[2:0]) + 1;
  endfunction

  function automatic logic [7:0] exp_ext(input logic [7:0] cf, int e);
    int s;
    s = sh(cf);
    return 8'((e + (s > 0 ? 1 << (s - 1) : 0)) >> s);
  endfunction

  // ********
  // Sequence
  // ********
  initial begin
    v = 8'($urandom(97658));
    tick(8);
    rst_b = 1'b1;
    cmp8(cntRdata, 8'h00);
    cmp8(cfgRdata, 8'hff);
    // Instruction clock: low, then high from the second edge
    for (int k = 0; k < 8; k++) begin
      tick(1);
      ph = {ph[6:0], instrClockOut};
    end
    cmp8(ph, 8'h66);
    // Idle pin in falling-edge mode must not count after reset
    cmp8(cntRdata, 8'h00);
    v = 8'($urandom);
    wcfg(v);
    cmp8(cfgRdata, v);
    tick(1);
    // Internal source with pin toggling; every ratio in turn
    run = 1'b1;
    for (int r = 0; r < 9; r++) begin
      c = (r == 0) ? 8'h08 : 8'(r - 1);
      c[4] = 1'($urandom);
      halfClks = 4'($urandom_range(5, 2));
      wcfg(c);
      v = 8'($urandom);
      wcnt(v);
      cmp8(cntRdata, v);
      tick(7);
      cmp8(cntRdata, v);
      tick(16 << sh(c));
      cmp_rng(8'(cntRdata - v), 8'h03, 8'h05);
    end
    wcfg(8'h08);
    wcnt(8'hff);
    wait_chg;
    cmp8(cntRdata, 8'h00);
    // Write clears the divider: 1:256 output must restart
    wcfg(8'h07);
    wcnt(8'h00);
    tick(300);
    wcnt(8'h00);
    tick(450);
    cmp8(cntRdata, 8'h00);
    // External source, both edges, bypass and two ratios
    for (int r = 0; r < 6; r++) begin
      run = 1'b0;
      c = {2'b00, 1'b1, 1'(r % 2), (r < 2) ? 4'h8 : 4'(r / 2 - 1)};
      tick(2);
      wcfg(c);
      wcnt(8'h00);
      tick(10);
      rises = 0;
      falls = 0;
      halfClks = 4'($urandom_range(5, 2));
      run = 1'b1;
      tick(60);
      run = 1'b0;
      tick(20);
      cmp8(cntRdata, exp_ext(c, c[4] ? falls : rises));
    end
    // Latency from a single qualifying pin edge
    wcfg({2'b00, 1'b1, countPin, 4'h8});
    wcnt(8'h00);
    tick(10);
    halfClks = 4'hf;
    run = 1'b1;
    wait_chg;
    run = 1'b0;
    cmp_rng(8'(($time - pinT) / 100), 8'h03, 8'h07);
    tally_and_finish;
  end
endmodule
